// *** rtl/rec_frame_pkg.sv ***
// Purpose: Shared widths, reset values and the framer state type for the record framing bus
// Assumes: One data clock, one channel per instance
// Notes:   Sample width and parallel count are defaults of module parameters
package rec_frame_pkg;
  localparam int          CHAN_A_SAMPLE_WIDTH   = 16;
  localparam int          CHAN_A_PARALLEL_COUNT = 8;
  localparam int          GP_WIDTH              = 16;
  localparam int          USER_ID_WIDTH         = 8;
  localparam int          REC_NUM_WIDTH         = 32;
  localparam logic [31:0] REC_NUM_RESET         = 32'h0000_0000;
  localparam logic [15:0] GP_RESET              = 16'h0000;
  localparam logic [7:0]  USER_ID_RESET         = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_OPEN   = 2'b01,
    ST_STREAM = 2'b10
  } frame_state_t;
endpackage

// *** rtl/frame_if.sv ***
// Purpose: Carries one qualified-rate bus beat between design modules
// Assumes: Widths match the top module parameters
// Notes:   Producer drives, consumer reads
`timescale 1ns/1ns
interface frame_if #(
  parameter int SW = 16,
  parameter int PC = 8,
  parameter int IW = 3
);
  logic [SW*PC-1:0] data;
  logic             valid;
  logic             start;
  logic             stop;
  logic [IW-1:0]    start_idx;
  logic [IW-1:0]    stop_idx;
  logic             overrange;
  modport producer (output data, valid, start, stop, start_idx, stop_idx, overrange);
  modport consumer (input data, valid, start, stop, start_idx, stop_idx, overrange);
endinterface

// *** rtl/overrange_detect.sv ***
// Purpose: Flags a beat in which any parallel sample sits at full scale
// Assumes: Two's complement, MSB aligned samples
// Notes:   Combinational; the top registers the flag
`timescale 1ns/1ns
module overrange_detect #(
  parameter int SW = 16,
  parameter int PC = 8
) (
  input  wire logic [SW*PC-1:0] data_i,
  output logic                  over_o
);
  logic [PC-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < PC; g++) begin : g_lane
      // Saturated at most negative or most positive code
      assign hit[g] = (data_i[g*SW +: SW] == {1'b1, {(SW-1){1'b0}}}) ||
                      (data_i[g*SW +: SW] == {1'b0, {(SW-1){1'b1}}});
    end
  endgenerate
  assign over_o = |hit;
endmodule

// *** rtl/frame_source.sv ***
// Purpose: Presents the full-rate input as qualified beats with overrange
// Assumes: Full-rate input carries data every cycle
// Notes:   Valid follows the qualify input so beats may be dropped
`timescale 1ns/1ns
module frame_source #(
  parameter int SW = 16,
  parameter int PC = 8,
  parameter int IW = 3
) (
  input  wire logic [SW*PC-1:0] data_i,
  input  wire logic             keep_i,
  input  wire logic             start_i,
  input  wire logic             stop_i,
  input  wire logic [IW-1:0]    start_idx_i,
  input  wire logic [IW-1:0]    stop_idx_i,
  frame_if.producer             bus
);
  logic over;
  overrange_detect #(.SW(SW), .PC(PC)) u_ovr (
    .data_i (data_i),
    .over_o (over)
  );
  assign bus.data      = data_i;
  assign bus.valid     = keep_i;
  assign bus.start     = start_i;
  assign bus.stop      = stop_i;
  assign bus.start_idx = start_idx_i;
  assign bus.stop_idx  = stop_idx_i;
  assign bus.overrange = over;
endmodule

// *** rtl/rec_framer.sv ***
// Purpose: Second user stage framer: qualifies, checks and numbers records
// Assumes: Inputs from the same data clock, acquisition flag from control logic
// Notes:   One register stage from input to output on every output
`timescale 1ns/1ns
module rec_framer
  import rec_frame_pkg::*;
#(
  parameter int SW = CHAN_A_SAMPLE_WIDTH,
  parameter int PC = CHAN_A_PARALLEL_COUNT,
  parameter int IW = (PC > 1) ? $clog2(PC) : 1
) (
  input  wire logic                     CLK_SYS_I,
  input  wire logic                     NRST_I,
  input  wire logic                     ACQ_ACTIVE_I,
  input  wire logic [SW*PC-1:0]         DATA_I,
  input  wire logic                     KEEP_I,
  input  wire logic                     START_I,
  input  wire logic                     STOP_I,
  input  wire logic [IW-1:0]            START_IDX_I,
  input  wire logic [IW-1:0]            STOP_IDX_I,
  input  wire logic [GP_WIDTH-1:0]      GP_I,
  input  wire logic [USER_ID_WIDTH-1:0] USER_ID_I,
  output logic [SW*PC-1:0]              DATA_O,
  output logic                          VALID_O,
  output logic                          OVERRANGE_O,
  output logic [GP_WIDTH-1:0]           GP_O,
  output logic                          START_O,
  output logic                          STOP_O,
  output logic [IW-1:0]                 START_IDX_O,
  output logic [IW-1:0]                 STOP_IDX_O,
  output logic [REC_NUM_WIDTH-1:0]      REC_NUM_O,
  output logic [USER_ID_WIDTH-1:0]      USER_ID_O,
  output logic [GP_WIDTH-1:0]           HDR_GP_O,
  output logic [USER_ID_WIDTH-1:0]      HDR_USER_ID_O,
  output logic                          HDR_STROBE_O,
  output logic                          OPEN_O,
  output logic                          DROP_O
);
  typedef struct packed {
    frame_state_t               st;
    logic [SW*PC-1:0]           data;
    logic                       valid;
    logic                       over;
    logic [GP_WIDTH-1:0]        gp;
    logic                       start;
    logic                       stop;
    logic [IW-1:0]              sidx;
    logic [IW-1:0]              eidx;
    logic [REC_NUM_WIDTH-1:0]   num;
    logic [REC_NUM_WIDTH-1:0]   next_num_cnt;
    logic [USER_ID_WIDTH-1:0]   uid;
    logic [GP_WIDTH-1:0]        hdr_gp;
    logic [USER_ID_WIDTH-1:0]   hdr_uid;
    logic                       hdr_stb;
    logic                       drop;
    logic                       acq_d;
  } state_t;

  state_t cur;
  state_t next_cur;

  frame_if #(.SW(SW), .PC(PC), .IW(IW)) beat ();

  frame_source #(.SW(SW), .PC(PC), .IW(IW)) u_src (
    .data_i      (DATA_I),
    .keep_i      (KEEP_I),
    .start_i     (START_I),
    .stop_i      (STOP_I),
    .start_idx_i (START_IDX_I),
    .stop_idx_i  (STOP_IDX_I),
    .bus         (beat)
  );

  // Flag counts only on a valid beat while acquisition runs
  function automatic logic takes(input logic flag, input logic vld, input logic acq);
    return flag && vld && acq;
  endfunction

  logic acc_start;
  logic acc_stop;
  logic restart;

  always_comb begin
    acc_start = takes(beat.start, beat.valid, ACQ_ACTIVE_I);
    acc_stop  = takes(beat.stop, beat.valid, ACQ_ACTIVE_I);
    restart   = ACQ_ACTIVE_I && !cur.acq_d;
    next_cur          = cur;
    next_cur.acq_d    = ACQ_ACTIVE_I;
    next_cur.data     = beat.data;
    next_cur.valid    = beat.valid;
    next_cur.over     = beat.overrange;
    next_cur.gp       = GP_I;
    next_cur.uid      = USER_ID_I;
    next_cur.sidx     = beat.start_idx;
    next_cur.eidx     = beat.stop_idx;
    next_cur.start    = 1'b0;
    next_cur.stop     = 1'b0;
    next_cur.hdr_stb  = 1'b0;
    next_cur.drop     = 1'b0;
    if (restart) begin
      next_cur.next_num_cnt = REC_NUM_RESET;
    end
    case (cur.st)
      ST_IDLE: begin
        // Both flags together is illegal; drop the pair
        if (acc_start && acc_stop) begin
          next_cur.drop = 1'b1;
        end else if (acc_start) begin
          next_cur.start = 1'b1;
          next_cur.st    = ST_OPEN;
        end else if (acc_stop) begin
          next_cur.drop = 1'b1;
        end
      end
      ST_OPEN, ST_STREAM: begin
        // A second start inside an open record would corrupt framing
        if (acc_start) begin
          next_cur.drop = 1'b1;
        end
        if (acc_stop && !acc_start) begin
          next_cur.stop = 1'b1;
          next_cur.st   = ST_IDLE;
        end else if (beat.valid) begin
          next_cur.st = ST_STREAM;
        end
        // Acquisition stops mid record: close it without a stop pulse
        if (!ACQ_ACTIVE_I) begin
          next_cur.stop = 1'b0;
          next_cur.st   = ST_IDLE;
        end
      end
      default: begin
        next_cur.st = ST_IDLE;
      end
    endcase
    if (next_cur.start) begin
      next_cur.num      = restart ? REC_NUM_RESET : cur.next_num_cnt;
      next_cur.next_num_cnt = REC_NUM_WIDTH'((restart ? REC_NUM_RESET : cur.next_num_cnt) + 1'b1);
      next_cur.hdr_gp   = GP_I;
      next_cur.hdr_uid  = USER_ID_I;
      next_cur.hdr_stb  = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      cur              <= '0;
      cur.st           <= ST_IDLE;
      cur.num          <= REC_NUM_RESET;
      cur.next_num_cnt <= REC_NUM_RESET;
      cur.gp           <= GP_RESET;
      cur.uid          <= USER_ID_RESET;
      cur.hdr_gp       <= GP_RESET;
      cur.hdr_uid      <= USER_ID_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // Full-rate path data always present; only valid gates it here
  assign DATA_O        = cur.data;
  assign VALID_O       = cur.valid;
  assign OVERRANGE_O   = cur.over;
  assign GP_O          = cur.gp;
  assign START_O       = cur.start;
  assign STOP_O        = cur.stop;
  assign START_IDX_O   = cur.sidx;
  assign STOP_IDX_O    = cur.eidx;
  assign REC_NUM_O     = cur.num;
  assign USER_ID_O     = cur.uid;
  assign HDR_GP_O      = cur.hdr_gp;
  assign HDR_USER_ID_O = cur.hdr_uid;
  assign HDR_STROBE_O  = cur.hdr_stb;
  assign OPEN_O        = (cur.st != ST_IDLE);
  assign DROP_O        = cur.drop;

  start_stop_excl_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    !(START_O && STOP_O)) else $error("start and stop together");
  flags_need_valid_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (START_O || STOP_O) |-> VALID_O) else $error("flag without valid");
  flags_need_acq_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (START_O || STOP_O) |-> $past(ACQ_ACTIVE_I)) else $error("flag outside acquisition");
  stop_after_open_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    STOP_O |-> !OPEN_O && $past(OPEN_O)) else $error("stop without open record");
  start_opens_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    START_O |-> OPEN_O && !$past(OPEN_O)) else $error("start inside open record");
  num_step_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (START_O && !$rose(cur.acq_d)) |-> REC_NUM_O == cur.next_num_cnt - 1'b1)
    else $error("record number did not step");
  hdr_capture_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    START_O |-> HDR_GP_O == $past(GP_I) && HDR_USER_ID_O == $past(USER_ID_I) && HDR_STROBE_O)
    else $error("header not captured at start");
  over_track_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    OVERRANGE_O == $past(beat.overrange)) else $error("overrange lost");
  stream_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (!NRST_I)
    (cur.st == ST_STREAM && !acc_stop && ACQ_ACTIVE_I) |=> OPEN_O || STOP_O)
    else $error("stream closed without stop");
endmodule

// *** dv/rec_sink.sv ***
// Purpose: Downstream record builder model watching the framer outputs
// Assumes: Output flags are one-cycle pulses on the data clock
// Notes:   Counts framing faults; the bench reads the count at the end
`timescale 1ns/1ns
module rec_sink (
  input  wire logic CLK_SYS_I,
  input  wire logic NRST_I,
  input  wire logic ACQ_I,
  input  wire logic VALID_I,
  input  wire logic START_I,
  input  wire logic STOP_I,
  output int        faults_o
);
  logic rec_open;
  always_ff @(posedge CLK_SYS_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rec_open <= 1'b0;
      faults_o <= 0;
    end else if (!ACQ_I) begin
      rec_open <= 1'b0;
    end else if ((START_I || STOP_I) && !VALID_I) begin
      faults_o <= faults_o + 1;
    end else if (VALID_I) begin
      // Second start while open would corrupt the host side
      if ((START_I && (rec_open || STOP_I)) || (STOP_I && !rec_open)) begin
        faults_o <= faults_o + 1;
      end else if (START_I || STOP_I) begin
        rec_open <= START_I;
      end
    end
  end
endmodule

// *** dv/digitizer_record_framing_bus_bench.sv ***
// Purpose: Self-checking bench for the record framer
// Assumes: Default widths, outputs one cycle behind inputs
// Notes:   Each cyc call checks the outputs of the previous beat
`timescale 1ns/1ns
module digitizer_record_framing_bus_bench;
  import rec_frame_pkg::*;
  localparam int DW = CHAN_A_SAMPLE_WIDTH * CHAN_A_PARALLEL_COUNT;
  logic          clk  = 1'b0;
  logic          nrst = 1'b0;
  logic          acq  = 1'b0;
  logic          keep = 1'b0;
  logic          st   = 1'b0;
  logic          sp   = 1'b0;
  logic [2:0]    sidx = 3'h0;
  logic [2:0]    pidx = 3'h0;
  logic [15:0]   gp   = 16'h0000;
  logic [7:0]    uid  = 8'h00;
  logic [DW-1:0] data = '0;
  logic [DW-1:0] d_o;
  logic [15:0]   gp_o, hg;
  logic [7:0]    uo, hu;
  logic [2:0]    sio, pio;
  logic [31:0]   rn;
  logic          v_o, ov, so, po, hs, op, dr;
  int            faults;
  int            mismatches = 0;
  int            n_checks   = 0;

  always #5 clk = ~clk;

  rec_framer rec_framer_inst (.CLK_SYS_I(clk), .NRST_I(nrst), .ACQ_ACTIVE_I(acq), .DATA_I(data),
    .KEEP_I(keep), .START_I(st), .STOP_I(sp), .START_IDX_I(sidx), .STOP_IDX_I(pidx), .GP_I(gp),
    .USER_ID_I(uid), .DATA_O(d_o), .VALID_O(v_o), .OVERRANGE_O(ov), .GP_O(gp_o), .START_O(so),
    .STOP_O(po), .START_IDX_O(sio), .STOP_IDX_O(pio), .REC_NUM_O(rn), .USER_ID_O(uo),
    .HDR_GP_O(hg), .HDR_USER_ID_O(hu), .HDR_STROBE_O(hs), .OPEN_O(op), .DROP_O(dr));

  rec_sink rec_sink_inst (.CLK_SYS_I(clk), .NRST_I(nrst), .ACQ_I(acq), .VALID_I(v_o),
    .START_I(so), .STOP_I(po), .faults_o(faults));

  task automatic close_out();
    if (mismatches == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // Flags seen: {start, stop, drop, valid, open}; g feeds gp, id, indexes, top lane
  task automatic cyc(input logic a, k, s, p, input logic [15:0] g, input logic [4:0] e);
    @(posedge clk);
    acq  <= a;
    keep <= k;
    st   <= s;
    sp   <= p;
    gp   <= g;
    uid  <= g[7:0];
    sidx <= g[2:0];
    pidx <= g[5:3];
    data <= {g, 112'h0};
    #1;
    chk("flags", {27'h0, e}, {27'h0, so, po, dr, v_o, op});
  endtask

  task automatic t_basic();
    cyc(1, 1, 0, 0, 16'h0000, 5'h00);
    cyc(1, 1, 1, 0, 16'h0005, 5'h02);
    cyc(1, 1, 0, 1, 16'h0030, 5'h13);
    chk("hdr gp", 32'h0000_0005, {16'h0, hg});
    chk("hdr id", 32'h0000_0005, {24'h0, hu});
    chk("hdr strobe", 32'h0000_0001, {31'h0, hs});
    chk("rec num", 32'h0000_0000, rn);
    chk("start idx", 32'h0000_0005, {29'h0, sio});
    cyc(1, 1, 1, 0, 16'h0007, 5'h0A);
    chk("stop idx", 32'h0000_0006, {29'h0, pio});
    cyc(1, 1, 0, 1, 16'h0000, 5'h13);
    chk("rec num", 32'h0000_0001, rn);
    chk("hdr gp", 32'h0000_0007, {16'h0, hg});
    cyc(1, 1, 0, 0, 16'h0000, 5'h0A);
  endtask

  task automatic t_gate();
    cyc(1, 0, 1, 0, 16'h0000, 5'h02);
    cyc(1, 1, 1, 0, 16'h0000, 5'h00);
    cyc(1, 0, 1, 0, 16'h0000, 5'h13);
    cyc(1, 0, 0, 1, 16'h0000, 5'h01);
    cyc(1, 1, 0, 1, 16'h0000, 5'h01);
    cyc(1, 0, 0, 1, 16'h0000, 5'h0A);
    cyc(1, 1, 0, 0, 16'h0000, 5'h00);
  endtask

  task automatic t_illegal();
    cyc(1, 1, 1, 1, 16'h0000, 5'h02);
    cyc(1, 1, 0, 1, 16'h0000, 5'h06);
    cyc(1, 1, 1, 0, 16'h0000, 5'h06);
    cyc(1, 1, 1, 0, 16'h0000, 5'h13);
    cyc(1, 1, 0, 1, 16'h0000, 5'h07);
    cyc(1, 1, 0, 0, 16'h0000, 5'h0A);
  endtask

  task automatic t_restart();
    cyc(0, 1, 1, 0, 16'h0000, 5'h02);
    cyc(1, 1, 0, 0, 16'h0000, 5'h02);
    cyc(1, 1, 1, 0, 16'h0000, 5'h02);
    cyc(1, 1, 0, 0, 16'h0000, 5'h13);
    chk("rec num", 32'h0000_0000, rn);
    repeat (4) cyc(1, 1, 0, 0, 16'h0000, 5'h03);
    // Acquisition stop ends the stream without a stop pulse
    cyc(0, 1, 0, 0, 16'h0000, 5'h03);
    cyc(1, 1, 0, 0, 16'h0000, 5'h02);
  endtask

  task automatic t_over();
    logic [15:0] tab [4];
    tab = '{16'h8000, 16'h7FFF, 16'h7FFE, 16'h8001};
    foreach (tab[i]) begin
      cyc(1, 1, 0, 0, tab[i], 5'h02);
      cyc(1, 1, 0, 0, 16'h0000, 5'h02);
      chk("overrange", {31'h0, i < 2}, {31'h0, ov});
      chk("top lane", {tab[i], 16'h0}, d_o[DW-1 -: 32]);
      chk("gp", {16'h0, tab[i]}, {16'h0, gp_o});
      chk("user id", {24'h0, tab[i][7:0]}, {24'h0, uo});
    end
  endtask

  initial begin
    #200_000;
    mismatches++;
    close_out();
  end

  initial begin
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    t_basic();
    t_gate();
    t_illegal();
    t_restart();
    t_over();
    chk("sink faults", 32'h0000_0000, faults);
    close_out();
  end
endmodule
